/* shared/mem_access_pkg.sv */
// Purpose: Constants for the indirect memory access port
// Assumes: 8-bit register space, 512-byte shadow SRAM and nonvolatile array
// Notes:   Offsets are register addresses seen by the serial front end
package mem_access_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFF_LIVE_CRC   = 8'h8A;
  localparam logic [7:0] OFF_PTR_HIGH   = 8'h8B;
  localparam logic [7:0] OFF_PTR_LOW    = 8'h8C;
  localparam logic [7:0] OFF_NV_WINDOW  = 8'h8D;
  localparam logic [7:0] OFF_SRAM_WIN   = 8'h8E;

  // ****************************************
  // Widths, fields and reset values
  // ****************************************
  localparam int         DATA_W         = 8;
  localparam int         PTR_W          = 12;
  localparam int         PTR_HIGH_W     = 4;
  localparam int         MEM_ADDR_W     = 9;
  localparam int         MEM_DEPTH      = 512;
  localparam logic [3:0] RST_PTR_HIGH   = 4'h0;
  localparam logic [7:0] RST_PTR_LOW    = 8'h00;
  localparam logic [7:0] RST_LIVE_CRC   = 8'h00;
  localparam logic [7:0] RST_RDATA      = 8'h00;
  localparam logic [8:0] RST_MEM_ADDR   = 9'h000;
  localparam logic [8:0] MEM_ADDR_STEP  = 9'h001;
  localparam logic [3:0] RESERVED_BITS  = 4'h0;
  localparam logic [7:0] CRC_POLY       = 8'h07;

  // ****************************************
  // Read sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SRAM = 2'b01,
    ST_NV   = 2'b10
  } rd_state_type;

endpackage : mem_access_pkg

/* rtl/sram_bank.sv */
// Purpose: Shadow SRAM, single port, registered read data
// Assumes: Write and read never requested in the same cycle by the caller
// Notes:   Contents are not reset; read data appears one cycle after addr
`timescale 1ns/1ps
`default_nettype none
module sram_bank
  import mem_access_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Access port
  input  wire logic                  wrEn,
  input  wire logic [MEM_ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0]     wrData,
  output logic      [DATA_W-1:0]     rdData_ff
);

  logic [DATA_W-1:0] store [MEM_DEPTH];

  always_ff @(posedge sys_clk)
  begin
    if (wrEn)
      store[addr] <= wrData;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rdData_ff <= RST_RDATA;
    else
      rdData_ff <= store[addr];
  end

endmodule : sram_bank
`default_nettype wire

/* rtl/indirect_memory_access_port.sv */
// Purpose: Indirect pointer and data windows into on-chip memories
// Assumes: Front end delivers one strobe at a time and waits for rdValid
// Notes:   Overview of the rules follows
// Overview of operation
// - Read-only live CRC byte, resets zero
// - High pointer nibble in bits 3:0
// - Low pointer byte, read/write, resets zero
// - Arrays use nine pointer bits, ROM twelve
// - First nonvolatile read returns pointer byte
// - Auto-incremented arrival counts as first access
// - Further nonvolatile reads advance address
// - Nonvolatile window locks register address
// - Transaction end releases nonvolatile lock
// - First SRAM access uses pointer address
// - Further SRAM accesses advance address
// - SRAM window locks register address
// - Transaction end ends SRAM streaming
// - Busy flag blocks nonvolatile access
`timescale 1ns/1ps
`default_nettype none
module indirect_memory_access_port
  import mem_access_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Transaction framing from the serial front end
  input  wire logic                  txnStart,
  input  wire logic                  txnEnd,
  // Register access strobes
  input  wire logic [7:0]            regAddr,
  input  wire logic                  regRead,
  input  wire logic                  regWrite,
  input  wire logic [DATA_W-1:0]     regWdata,
  output logic      [DATA_W-1:0]     regRdata_ff,
  output logic                       rdValid_ff,
  output logic                       addrHold_ff,
  // Nonvolatile array read port
  input  wire logic                  programInProgress,
  output logic                       nvReadReq_ff,
  output logic      [MEM_ADDR_W-1:0] nvAddr_ff,
  input  wire logic                  nvRdValid,
  input  wire logic [DATA_W-1:0]     nvRdata,
  // Full pointer for the ROM window
  output logic      [PTR_HIGH_W-1:0] ptrHigh_ff,
  output logic      [DATA_W-1:0]     ptrLow_ff
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [MEM_ADDR_W-1:0] nextAddr(input logic locked,
      input logic [MEM_ADDR_W-1:0] cur, input logic [MEM_ADDR_W-1:0] base);
    nextAddr = locked ? cur + MEM_ADDR_STEP : base;
  endfunction : nextAddr

  function automatic logic [7:0] crcStep(input logic [7:0] crc,
      input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++)
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    crcStep = c;
  endfunction : crcStep

  // ****************************************
  // State
  // ****************************************
  rd_state_type          state_ff;
  rd_state_type          nxt_state;
  logic                  lockNv_ff;
  logic                  lockSram_ff;
  logic [MEM_ADDR_W-1:0] streamAddr_ff;
  logic [7:0]            liveCrc_ff;
  logic [DATA_W-1:0]     sramRdata;

  // ****************************************
  // Decode
  // ****************************************
  wire                  idle      = (state_ff == ST_IDLE);
  wire                  readTake  = regRead && idle;
  wire                  writeTake = regWrite && idle;
  wire                  isCrc     = (regAddr == OFF_LIVE_CRC);
  wire                  isPtrHigh = (regAddr == OFF_PTR_HIGH);
  wire                  isPtrLow  = (regAddr == OFF_PTR_LOW);
  wire                  isNvWin   = (regAddr == OFF_NV_WINDOW);
  wire                  isSramWin = (regAddr == OFF_SRAM_WIN);
  wire                  frameEdge = txnStart || txnEnd;
  wire                  winNv     = readTake && isNvWin && !programInProgress;
  wire                  winSram   = (readTake || writeTake) && isSramWin;
  wire [MEM_ADDR_W-1:0] ptrArray  = {ptrHigh_ff[0], ptrLow_ff};
  wire [MEM_ADDR_W-1:0] nvNext    = nextAddr(lockNv_ff, streamAddr_ff, ptrArray);
  wire [MEM_ADDR_W-1:0] sramNext  = nextAddr(lockSram_ff, streamAddr_ff, ptrArray);
  wire [MEM_ADDR_W-1:0] sramAddr  = winSram ? sramNext : streamAddr_ff;
  wire                  sramWr    = writeTake && isSramWin;
  // Windows, and nonvolatile reads under busy, read as zero here
  wire [DATA_W-1:0]     regMux    = isCrc     ? liveCrc_ff :
                                    isPtrHigh ? {RESERVED_BITS, ptrHigh_ff} :
                                    isPtrLow  ? ptrLow_ff : RST_RDATA;

  // ****************************************
  // Shadow SRAM
  // ****************************************
  sram_bank u_sram (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .wrEn      (sramWr),
    .addr      (sramAddr),
    .wrData    (regWdata),
    .rdData_ff (sramRdata)
  );

  // ****************************************
  // Pointer registers
  // ****************************************
  // pointer untouched by streaming
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ptrHigh_ff <= RST_PTR_HIGH;
      ptrLow_ff  <= RST_PTR_LOW;
    end
    else if (writeTake)
    begin
      if (isPtrHigh)
        ptrHigh_ff <= regWdata[PTR_HIGH_W-1:0];
      if (isPtrLow)
        ptrLow_ff <= regWdata;
    end
  end

  // ****************************************
  // Window locks and stream address
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      lockNv_ff     <= 1'b0;
      lockSram_ff   <= 1'b0;
      addrHold_ff   <= 1'b0;
      streamAddr_ff <= RST_MEM_ADDR;
    end
    else if (frameEdge)
    begin
      lockNv_ff   <= 1'b0;
      lockSram_ff <= 1'b0;
      addrHold_ff <= 1'b0;
    end
    else if (winNv)
    begin
      lockNv_ff     <= 1'b1;
      addrHold_ff   <= 1'b1;
      streamAddr_ff <= nvNext;
    end
    else if (winSram)
    begin
      lockSram_ff   <= 1'b1;
      addrHold_ff   <= 1'b1;
      streamAddr_ff <= sramNext;
    end
  end

  // ****************************************
  // Read sequencer
  // ****************************************
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (winNv)
          nxt_state = ST_NV;
        else if (winSram && regRead)
          nxt_state = ST_SRAM;
      ST_SRAM:
        nxt_state = ST_IDLE;
      ST_NV:
        if (nvRdValid)
          nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      nvReadReq_ff <= 1'b0;
      nvAddr_ff    <= RST_MEM_ADDR;
    end
    else
    begin
      nvReadReq_ff <= winNv;
      if (winNv)
        nvAddr_ff <= nvNext;
    end
  end

  // Register reads answer next cycle; SRAM waits for its registered data
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      regRdata_ff <= RST_RDATA;
      rdValid_ff  <= 1'b0;
    end
    else if (state_ff == ST_SRAM)
    begin
      regRdata_ff <= sramRdata;
      rdValid_ff  <= 1'b1;
    end
    else if (state_ff == ST_NV)
    begin
      regRdata_ff <= nvRdValid ? nvRdata : regRdata_ff;
      rdValid_ff  <= nvRdValid;
    end
    else if (readTake && !winNv && !winSram)
    begin
      regRdata_ff <= regMux;
      rdValid_ff  <= 1'b1;
    end
    else
      rdValid_ff <= 1'b0;
  end

  // ****************************************
  // Live CRC
  // ****************************************
  // crc only from array bytes
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      liveCrc_ff <= RST_LIVE_CRC;
    else if (state_ff == ST_NV && nvRdValid)
      liveCrc_ff <= crcStep(liveCrc_ff, nvRdata);
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_sramRead;
    readTake && winSram ##1 state_ff == ST_SRAM ##1 rdValid_ff;
  endsequence

  sequence s_firstNv;
    winNv && !lockNv_ff && !frameEdge;
  endsequence

  property p_crcRo;
    @(posedge sys_clk) disable iff (rst)
      writeTake && isCrc |=> $stable(liveCrc_ff);
  endproperty
  a_crcRo: assert property (p_crcRo) else $error("crc changed by write");

  property p_highRsv;
    @(posedge sys_clk) disable iff (rst)
      readTake && isPtrHigh |=> rdValid_ff && regRdata_ff[7:4] == 4'h0;
  endproperty
  a_highRsv: assert property (p_highRsv) else $error("reserved bits set");

  property p_lowWr;
    @(posedge sys_clk) disable iff (rst)
      writeTake && isPtrLow |=> ptrLow_ff == $past(regWdata);
  endproperty
  a_lowWr: assert property (p_lowWr) else $error("low pointer not stored");

  property p_firstNv;
    @(posedge sys_clk) disable iff (rst)
      s_firstNv |=> nvReadReq_ff && nvAddr_ff == $past(ptrArray) && addrHold_ff;
  endproperty
  a_firstNv: assert property (p_firstNv) else $error("first nv addr wrong");

  property p_nextNv;
    @(posedge sys_clk) disable iff (rst)
      winNv && lockNv_ff && !frameEdge |=> nvAddr_ff == $past(streamAddr_ff) + 9'h001;
  endproperty
  a_nextNv: assert property (p_nextNv) else $error("nv addr not advanced");

  property p_release;
    @(posedge sys_clk) disable iff (rst)
      txnEnd |=> !addrHold_ff && !lockNv_ff && !lockSram_ff;
  endproperty
  a_release: assert property (p_release) else $error("lock survives end");

  property p_sramRead;
    @(posedge sys_clk) disable iff (rst)
      readTake && winSram |-> s_sramRead;
  endproperty
  a_sramRead: assert property (p_sramRead) else $error("sram read late");

  property p_sramLock;
    @(posedge sys_clk) disable iff (rst)
      winSram && !frameEdge |=> addrHold_ff && lockSram_ff;
  endproperty
  a_sramLock: assert property (p_sramLock) else $error("sram not locked");

  property p_busy;
    @(posedge sys_clk) disable iff (rst)
      readTake && isNvWin && programInProgress
        |=> !nvReadReq_ff && rdValid_ff && regRdata_ff == 8'h00;
  endproperty
  a_busy: assert property (p_busy) else $error("nv access while busy");

  property p_ptrKept;
    @(posedge sys_clk) disable iff (rst)
      (winNv || winSram) |=> $stable(ptrLow_ff) && $stable(ptrHigh_ff);
  endproperty
  a_ptrKept: assert property (p_ptrKept) else $error("pointer moved");

  property p_nvWrIgn;
    @(posedge sys_clk) disable iff (rst)
      regWrite && isNvWin |=> !nvReadReq_ff;
  endproperty
  a_nvWrIgn: assert property (p_nvWrIgn) else $error("nv window write acted");

endmodule : indirect_memory_access_port
`default_nettype wire

/* test/nv_array_model.sv */
// Purpose: Nonvolatile array model answering byte read requests
// Assumes: One request outstanding at a time
// Notes:   Byte value is a fixed function of its address
`timescale 1ns/1ps
`default_nettype none
module nv_array_model
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Read port
  input  wire logic       nvReq,
  input  wire logic [8:0] nvAddr,
  input  wire logic [3:0] latency,
  output logic            nvRdValid,
  output logic [7:0]      nvRdata
);
  logic [8:0] addrHeld;
  logic [4:0] waitCnt;

  // Data toggles outside the valid cycle so a sample one cycle late never matches
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      addrHeld  <= 9'h000;
      waitCnt   <= 5'h00;
      nvRdValid <= 1'b0;
      nvRdata   <= 8'h00;
    end
    else if (nvReq)
    begin
      addrHeld  <= nvAddr;
      waitCnt   <= {1'b0, latency} + 5'h01;
      nvRdValid <= 1'b0;
      nvRdata   <= ~nvRdata;
    end
    else if (waitCnt == 5'h01)
    begin
      waitCnt   <= 5'h00;
      nvRdValid <= 1'b1;
      nvRdata   <= {addrHeld[8], 7'h2B} ^ addrHeld[7:0];
    end
    else
    begin
      waitCnt   <= (waitCnt == 5'h00) ? 5'h00 : waitCnt - 5'h01;
      nvRdValid <= 1'b0;
      nvRdata   <= ~nvRdata;
    end
  end
endmodule : nv_array_model
`default_nettype wire

/* test/testbench.sv */
// Purpose: Self-checking bench for the indirect memory access port
// Assumes: Front end strobes one access at a time
// Notes:   Pointers other than the first (9'h1FE), data and array latency are random from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module testbench
  import mem_access_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       txnStart = 1'b0;
  logic       txnEnd = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic       regRead = 1'b0;
  logic       regWrite = 1'b0;
  logic [7:0] regWdata = 8'h00;
  logic       programInProgress = 1'b0;
  logic [3:0] latency = 4'h0;
  logic [7:0] regRdata_ff, nvRdata, got, crc, wbuf[4];
  logic [8:0] nvAddr_ff, ptr, ea, seenAddr;
  logic [7:0] ptrLow_ff;
  logic [3:0] ptrHigh_ff;
  logic       rdValid_ff, addrHold_ff, nvReadReq_ff, nvRdValid, gotReq;
  logic [7:0] regs[4] = '{OFF_LIVE_CRC, OFF_PTR_HIGH, OFF_PTR_LOW, 8'h8F};
  int         fail_count = 0;
  int         tests_run = 0;

  always #10 sys_clk = ~sys_clk;

  indirect_memory_access_port dut (.sys_clk(sys_clk), .rst(rst), .txnStart(txnStart),
    .txnEnd(txnEnd), .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata_ff(regRdata_ff), .rdValid_ff(rdValid_ff),
    .addrHold_ff(addrHold_ff), .programInProgress(programInProgress),
    .nvReadReq_ff(nvReadReq_ff), .nvAddr_ff(nvAddr_ff), .nvRdValid(nvRdValid),
    .nvRdata(nvRdata), .ptrHigh_ff(ptrHigh_ff), .ptrLow_ff(ptrLow_ff));

  nv_array_model nvm (.sys_clk(sys_clk), .rst(rst), .nvReq(nvReadReq_ff),
    .nvAddr(nvAddr_ff), .latency(latency), .nvRdValid(nvRdValid), .nvRdata(nvRdata));

  // ****************************************
  // Expectations, compare and bus tasks
  // ****************************************
  function automatic logic [7:0] nvByte(input logic [8:0] a);
    return {a[8], 7'h2B} ^ a[7:0];
  endfunction : nvByte

  function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    return r;
  endfunction : crcStep

  task automatic test_done;
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] seen);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : wr

  // Bounded wait on the answer; the request address is caught on the way
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    gotReq = 1'b0;
    @(posedge sys_clk);
    regRead <= 1'b0;
    // Look just after the taking edge first: simple answers stand one cycle only
    for (n = 0; n < 40; n++)
    begin
      #1;
      if (nvReadReq_ff === 1'b1)
      begin
        gotReq = 1'b1;
        seenAddr = nvAddr_ff;
      end
      if (rdValid_ff === 1'b1)
        break;
      @(posedge sys_clk);
    end
    if (n == 40)
    begin
      fail_count++;
      $display("unexpected read answer: expected 1, seen 0");
      test_done();
    end
    got = regRdata_ff;
  endtask : rd

  task automatic pulse(input logic isEnd);
    @(posedge sys_clk);
    txnStart <= !isEnd;
    txnEnd   <= isEnd;
    @(posedge sys_clk);
    txnStart <= 1'b0;
    txnEnd   <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : pulse

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    void'($urandom(63049));
    crc = 8'h00;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (regs[i])
    begin
      rd(regs[i]);
      chk("reset or unmapped read", 12'h000, {4'h0, got});
    end
    wr(OFF_PTR_HIGH, 8'hFF);
    rd(OFF_PTR_HIGH);
    chk("pointer high", 12'h00F, {4'h0, got});
    chk("rom pointer", 12'hF00, {ptrHigh_ff, ptrLow_ff});
    wr(OFF_LIVE_CRC, 8'($urandom));
    for (int t = 0; t < 3; t++)
    begin
      ptr = (t == 0) ? 9'h1FE : 9'($urandom);
      wr(OFF_PTR_HIGH, {4'h0, 3'($urandom), ptr[8]});
      wr(OFF_PTR_LOW, ptr[7:0]);
      repeat (2)
      begin
        pulse(1'b0);
        for (int i = 0; i < 4; i++)
        begin
          ea = ptr + 9'(i);
          latency <= 4'($urandom);
          rd(OFF_NV_WINDOW);
          chk("nv address", {3'h0, ea}, {3'h0, seenAddr});
          chk("nv data", {4'h0, nvByte(ea)}, {4'h0, got});
          chk("address hold", 12'h001, {11'h0, addrHold_ff});
          crc = crcStep(crc, nvByte(ea));
        end
        pulse(1'b1);
        chk("address hold", 12'h000, {11'h0, addrHold_ff});
      end
      rd(OFF_LIVE_CRC);
      chk("live crc", {4'h0, crc}, {4'h0, got});
      rd(OFF_PTR_LOW);
      chk("pointer low", {4'h0, ptr[7:0]}, {4'h0, got});
    end
    ptr = 9'($urandom);
    wr(OFF_PTR_HIGH, {7'h00, ptr[8]});
    wr(OFF_PTR_LOW, ptr[7:0]);
    pulse(1'b0);
    foreach (wbuf[i])
    begin
      wbuf[i] = 8'($urandom);
      wr(OFF_SRAM_WIN, wbuf[i]);
    end
    pulse(1'b1);
    pulse(1'b0);
    foreach (wbuf[i])
    begin
      rd(OFF_SRAM_WIN);
      chk("sram data", {4'h0, wbuf[i]}, {4'h0, got});
    end
    chk("address hold", 12'h001, {11'h0, addrHold_ff});
    pulse(1'b1);
    pulse(1'b0);
    wr(OFF_NV_WINDOW, 8'($urandom));
    rd(OFF_LIVE_CRC);
    chk("address hold", 12'h000, {11'h0, addrHold_ff});
    @(posedge sys_clk);
    programInProgress <= 1'b1;
    rd(OFF_NV_WINDOW);
    chk("busy data", 12'h000, {4'h0, got});
    chk("busy request", 12'h000, {11'h0, gotReq});
    @(posedge sys_clk);
    programInProgress <= 1'b0;
    rd(OFF_NV_WINDOW);
    chk("nv data after busy", {4'h0, nvByte(ptr)}, {4'h0, got});
    pulse(1'b1);
    test_done();
  end
endmodule : testbench
`default_nettype wire
